//--- core/sbg_pkg.sv
// constants and state codes shared by the sonar burst and gain sequencer
// assumes one system clock; every count below is in system-clock periods
package sbg_pkg;

   // ----------------------------------------------------------------
   // burst, gain and repetition counts
   // ----------------------------------------------------------------
   localparam int unsigned BURST_MAX_CYCLES = 396; // longest burst gate
   localparam int unsigned GAIN_STEP_CYCLES = 220; // length of one gain step
   localparam int unsigned GAIN_STEPS = 32; // number of gain steps
   localparam int unsigned REPEAT_GAP_CYCLES = 9900; // extra dead time

   // ----------------------------------------------------------------
   // counter widths and reset values
   // ----------------------------------------------------------------
   localparam int unsigned BURST_W = 9; // holds up to 396
   localparam int unsigned GUARD_W = 14; // holds up to 9900
   localparam int unsigned TIMER_W = 8; // holds up to 219
   localparam int unsigned STEP_W = 5; // holds steps 0..31
   localparam logic [4:0] GAIN_STEP_RESET = 5'h00; // minimum gain

   // ----------------------------------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SBG_IDLE = 4'h1, // no burst yet since reset
      SBG_BURST = 4'h2, // oscillator gated on
      SBG_HOLD = 4'h4, // burst capped, host still low
      SBG_LISTEN = 4'h8 // gain stepping, echo reported
   } sbg_state_t;

endpackage

//--- core/sbg_gain_if.sv
// carrier between the sequencer and its gain stepper
// assumes both ends share the system clock
`timescale 1ns/1ps
interface sbg_gain_if;
   logic restart; // one-cycle pulse: back to minimum gain
   logic start; // one-cycle pulse: trigger pulse has ended
   logic [4:0] step; // current gain step, registered
   logic at_max; // final step reached, registered

   modport ctrl (output restart, output start, input step, input at_max);
   modport stepper (input restart, input start, output step, output at_max);
endinterface

//--- core/sbg_gain_stepper.sv
// time-controlled gain step counter
// assumes restart and start are one-cycle pulses in the clock domain
`timescale 1ns/1ps
module sbg_gain_stepper #(
   parameter int unsigned STEP_CYCLES = sbg_pkg::GAIN_STEP_CYCLES,
   parameter int unsigned STEPS = sbg_pkg::GAIN_STEPS
) (
   input wire logic clock,
   input wire logic rst_n,
   sbg_gain_if.stepper gif
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic running; // counting towards the next step
      logic [sbg_pkg::TIMER_W-1:0] timer; // cycles into the current step
      logic [sbg_pkg::STEP_W-1:0] step; // gain step
      logic at_max; // final step flag, kept in a flop for the pin
   } sbg_step_st_t;

   localparam logic [sbg_pkg::TIMER_W-1:0] LAST_TICK =
      sbg_pkg::TIMER_W'(STEP_CYCLES - 1);
   localparam logic [sbg_pkg::STEP_W-1:0] LAST_STEP =
      sbg_pkg::STEP_W'(STEPS - 1);

   sbg_step_st_t st; // registered state
   sbg_step_st_t next_st; // next state

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // restart outranks start, so a new trigger always wins
   always_comb begin
      next_st = st;
      if (gif.restart) begin
         next_st.running = 1'b0;
         next_st.timer = '0;
         next_st.step = sbg_pkg::GAIN_STEP_RESET;
      end else if (gif.start) begin
         next_st.running = 1'b1;
         next_st.timer = '0;
      end else if (st.running) begin
         if (st.step == LAST_STEP) begin
            // top gain is held until the next restart
            next_st.running = 1'b0;
         end else if (st.timer == LAST_TICK) begin
            next_st.timer = '0;
            next_st.step = st.step + 1'b1;
         end else begin
            next_st.timer = st.timer + 1'b1;
         end
      end
      // flag follows the next step so it never lags the step pins
      next_st.at_max = (next_st.step == LAST_STEP);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign gif.step = st.step;
   assign gif.at_max = st.at_max;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   step_period_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (st.step != $past(st.step) && st.step != '0)
         |-> ($past(st.timer) == LAST_TICK && $past(st.running)))
      else $error("gain step advanced off its period");

endmodule

//--- core/sbg_sequencer.sv
// burst gate, trigger guard, gain timing and echo report of a sonar front end
// assumes line_in is the sampled level of the shared open-collector line,
// echo_above the synchronous comparator result, and the clock is the
// system clock that all counts are measured in
`timescale 1ns/1ps
module sbg_sequencer #(
   parameter int unsigned REPEAT_GAP = sbg_pkg::REPEAT_GAP_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_n,
   input wire logic echo_above,
   output logic burst_enable,
   output logic [4:0] time_gain_stage_out,
   output logic gain_at_max
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      sbg_pkg::sbg_state_t mode; // sequence state
      logic line_prev; // line level one cycle ago
      logic drive; // pulling the line low
      logic drive_prev; // pulled low one cycle ago
      logic burst; // oscillator gate
      logic [sbg_pkg::BURST_W-1:0] width; // burst cycles so far
      logic [sbg_pkg::GUARD_W-1:0] guard; // dead time left
      logic oe_n; // line drive enable, active low
   } sbg_seq_st_t;

   localparam logic [sbg_pkg::BURST_W-1:0] BURST_LAST =
      sbg_pkg::BURST_W'(sbg_pkg::BURST_MAX_CYCLES);
   localparam logic [sbg_pkg::GUARD_W-1:0] GUARD_LOAD =
      sbg_pkg::GUARD_W'(REPEAT_GAP);
   localparam sbg_seq_st_t SEQ_RESET = '{
      mode: sbg_pkg::SBG_IDLE, line_prev: 1'b1, drive: 1'b0,
      drive_prev: 1'b0, burst: 1'b0, width: '0, guard: '0, oe_n: 1'b1};

   sbg_seq_st_t st; // registered state
   sbg_seq_st_t next_st; // next state
   logic host_fall; // host has just pulled the line low
   logic accept; // trigger taken
   logic pulse_end; // trigger pulse released
   logic burst_stop; // burst gate closes this cycle

   sbg_gain_if gif (); // link to the gain stepper

   // ----------------------------------------------------------------
   // gain stepper
   // ----------------------------------------------------------------
   sbg_gain_stepper u_stepper (
      .clock(clock),
      .rst_n(rst_n),
      .gif(gif.stepper)
   );

   // ----------------------------------------------------------------
   // trigger recognition
   // ----------------------------------------------------------------
   // a low caused by our own echo drive is masked for one cycle after
   // release; a host pull during our drive cannot be seen at all
   always_comb begin
      host_fall = st.line_prev && !line_in && !st.drive && !st.drive_prev;
      accept = host_fall && (st.guard == '0);
      pulse_end = line_in && (st.mode == sbg_pkg::SBG_BURST ||
                              st.mode == sbg_pkg::SBG_HOLD);
      burst_stop = (st.mode == sbg_pkg::SBG_BURST) &&
                   (line_in || st.width == BURST_LAST);
   end

   assign gif.restart = accept;
   assign gif.start = pulse_end;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.line_prev = line_in;
      next_st.drive_prev = st.drive;
      // dead time runs down once per cycle
      if (st.guard != '0) begin
         next_st.guard = st.guard - 1'b1;
      end
      unique case (st.mode)
         sbg_pkg::SBG_IDLE, sbg_pkg::SBG_LISTEN: begin
            if (accept) begin
               // burst length follows the host's low width
               next_st.mode = sbg_pkg::SBG_BURST;
               next_st.burst = 1'b1;
               next_st.width = sbg_pkg::BURST_W'(1);
               next_st.drive = 1'b0;
            end else begin
               // echo only reported once a burst has gone out
               next_st.drive = (st.mode == sbg_pkg::SBG_LISTEN) &&
                               echo_above;
            end
         end
         sbg_pkg::SBG_BURST: begin
            if (line_in) begin
               next_st.mode = sbg_pkg::SBG_LISTEN;
               next_st.burst = 1'b0;
            end else if (st.width == BURST_LAST) begin
               // excess low time gives no more cycles
               next_st.mode = sbg_pkg::SBG_HOLD;
               next_st.burst = 1'b0;
            end else begin
               next_st.width = st.width + 1'b1;
            end
            // width counted is the gated one, so the gap is width + gap
            if (burst_stop) begin
               next_st.guard = GUARD_LOAD;
            end
         end
         sbg_pkg::SBG_HOLD: begin
            if (line_in) begin
               next_st.mode = sbg_pkg::SBG_LISTEN;
            end
         end
         default: begin
            next_st = SEQ_RESET;
         end
      endcase
      // enable kept in its own flop so the pin has no inverter glitch
      next_st.oe_n = !next_st.drive;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= SEQ_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the line is only ever pulled low; the pull-up gives the high level
   assign line_out = 1'b0;
   assign line_oe_n = st.oe_n;
   assign burst_enable = st.burst;
   assign time_gain_stage_out = gif.step;
   assign gain_at_max = gif.at_max;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [sbg_pkg::BURST_W:0] gate_run; // helper: burst length so far

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gate_run <= '0;
      end else if (burst_enable) begin
         gate_run <= gate_run + 1'b1;
      end else begin
         gate_run <= '0;
      end
   end

   burst_gate_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      $rose(burst_enable) |-> !$past(line_in) && $past(line_in, 2))
      else $error("burst opened without a host low");

   burst_end_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      burst_enable && line_in |=> !burst_enable)
      else $error("burst kept running after line release");

   burst_cap_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      gate_run <= (sbg_pkg::BURST_W + 1)'(sbg_pkg::BURST_MAX_CYCLES))
      else $error("burst longer than its cap");

   guard_block_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      (st.guard != '0 && !burst_enable) |=> !$rose(burst_enable))
      else $error("trigger taken inside dead time");

   guard_load_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      $fell(burst_enable) |-> st.guard == GUARD_LOAD)
      else $error("dead time not loaded at burst end");

   gain_reset_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      $rose(burst_enable) |-> time_gain_stage_out == 5'h00)
      else $error("gain not back at first step on trigger");

   gain_still_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      burst_enable |=> time_gain_stage_out == 5'h00)
      else $error("gain moved during the burst");

   gain_hold_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      gain_at_max && !accept |=> gain_at_max)
      else $error("top gain left without a trigger");

   echo_drive_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      !line_oe_n |-> $past(echo_above) && !burst_enable)
      else $error("line pulled low without an echo");

   line_release_a: assert property (
      @(posedge clock) disable iff (!rst_n)
      line_out == 1'b0 && (!burst_enable || line_oe_n))
      else $error("line driven high or during burst");

endmodule

//--- tb/sbg_host_model.sv
// host side of the shared open-collector trigger and echo line
// assumes the bench asks for a pull-low through pull, set after an edge
`timescale 1ns/1ps
module sbg_host_model (
   input wire logic pull,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   output logic line
);
   // ----------------------------------------------------------------
   // wired line with pull-up
   // ----------------------------------------------------------------
   // the host only ever pulls low, and the width of that pull sets
   // the burst length up to the cap; released, the pull-up wins unless the device pulls low
   always_comb begin
      if (pull) begin
         line = 1'b0;
      end else if (!dev_oe_n) begin
         line = dev_out; // device pull; a high here would be illegal
      end else begin
         line = 1'b1; // pull-up level
      end
   end
endmodule

//--- tb/sonar_burst_and_gain_sequencer_tb.sv
// self-checking bench for the sonar burst and gain sequencer
// assumes dead time shortened to GAP; all other counts as in the package
`timescale 1ns/1ps
module sonar_burst_and_gain_sequencer_tb;
   localparam int unsigned GAP = 40; // short dead time keeps the run brief
   logic clock = 1'b0; // system clock, 100 MHz
   logic rst_n = 1'b0; // async reset, active low
   logic pull = 1'b0; // host pull request
   logic echo_above = 1'b0; // comparator result
   logic line; // resolved shared line
   logic line_out;
   logic line_oe_n;
   logic burst_enable;
   logic [4:0] time_gain_stage_out;
   logic gain_at_max;
   int num_errors = 0; // mismatches seen
   int n_checks = 0; // comparisons made
   int bcount = 0; // burst cycles since last clear

   // ----------------------------------------------------------------
   // clock, parts and monitor
   // ----------------------------------------------------------------
   always #5 clock = ~clock;

   sbg_host_model u_host (
      .pull(pull),
      .dev_out(line_out),
      .dev_oe_n(line_oe_n),
      .line(line)
   );

   sbg_sequencer #(.REPEAT_GAP(GAP)) u_dut (
      .clock(clock),
      .rst_n(rst_n),
      .line_in(line),
      .line_out(line_out),
      .line_oe_n(line_oe_n),
      .echo_above(echo_above),
      .burst_enable(burst_enable),
      .time_gain_stage_out(time_gain_stage_out),
      .gain_at_max(gain_at_max)
   );

   // counts gated burst cycles at each edge
   always @(posedge clock) begin
      if (burst_enable === 1'b1) begin
         bcount <= bcount + 1;
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // host low pulse of w cycles; returns just after the release edge
   task automatic pulse(input int w);
      bcount = 0;
      pull = 1'b1;
      repeat (w) @(posedge clock);
      #1 pull = 1'b0;
      @(posedge clock);
      #1;
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // short trigger: burst lasts exactly the low width
   task automatic s_short();
      pulse(20);
      check("burst cycles short", bcount, 32'h14);
      check("burst after release", burst_enable, 1'b0);
      check("line out level", line_out, 1'b0);
      wait_cycles(GAP + 4);
   endtask

   // over-long trigger: burst capped, excess low time ignored
   task automatic s_cap();
      pulse(450);
      check("burst cycles capped", bcount, 32'h18C);
      wait_cycles(GAP + 4);
   endtask

   // gain walk from release to the final step, then held
   task automatic s_gain();
      pulse(10);
      check("gain at start", time_gain_stage_out, 5'h00);
      wait_cycles(220 - 3);
      check("gain before step 1", time_gain_stage_out, 5'h00);
      wait_cycles(6);
      check("gain step 1", time_gain_stage_out, 5'h01);
      wait_cycles(220 * 30 - 6);
      check("gain before last", time_gain_stage_out, 5'h1E);
      wait_cycles(6);
      check("gain last step", time_gain_stage_out, 5'h1F);
      check("gain at max", gain_at_max, 1'b1);
      wait_cycles(900);
      check("gain held", time_gain_stage_out, 5'h1F);
   endtask

   // trigger inside dead time refused, later one accepted and resets gain
   task automatic s_guard();
      pulse(8);
      wait_cycles(220 * 32);
      check("gain max again", time_gain_stage_out, 5'h1F);
      pulse(8); // release set dead time; retrigger 5 cycles later
      wait_cycles(5);
      pulse(8);
      check("early trigger burst", bcount, 32'h0);
      // a refused pulse leaves the stepper on the earlier release's
      // timing, so step 1 shows here; a taken one would still be at 0
      wait_cycles(210);
      check("early trigger gain", time_gain_stage_out, 5'h01);
      bcount = 0;
      pull = 1'b1;
      wait_cycles(3);
      check("new trigger gain", time_gain_stage_out, 5'h00);
      check("new trigger burst", burst_enable, 1'b1);
      pull = 1'b0;
      wait_cycles(GAP + 4);
   endtask

   // echo before any burst must not reach the line
   task automatic s_idle_echo();
      echo_above = 1'b1;
      wait_cycles(3);
      check("echo before burst", line_oe_n, 1'b1);
      echo_above = 1'b0;
      wait_cycles(2);
   endtask

   // echo above threshold pulls the line low, one cycle behind
   task automatic s_echo();
      echo_above = 1'b1;
      wait_cycles(2);
      check("echo drive", line_oe_n, 1'b0);
      check("echo line", line, 1'b0);
      wait_cycles(30);
      check("echo held", line_oe_n, 1'b0);
      check("no burst on echo", burst_enable, 1'b0);
      echo_above = 1'b0;
      wait_cycles(2);
      check("echo release", line_oe_n, 1'b1);
      check("line released", line, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      #1 rst_n = 1'b1;
      check("reset burst", burst_enable, 1'b0);
      check("reset drive", line_oe_n, 1'b1);
      check("reset gain", time_gain_stage_out, 5'h00);
      wait_cycles(2);
      s_idle_echo();
      s_short();
      s_cap();
      s_gain();
      s_guard();
      s_echo();
      end_of_test();
   end

   // the whole run is well under 40000 cycles
   initial begin
      #500000;
      num_errors++;
      end_of_test();
   end
endmodule
